// ==== common/pad_cell_pkg.sv ====
// constants, configuration layout and carriers for the pad cell
// Summary of operation
// - bidirectional buffer with SDR/DDR registers both ways
// - per path, bypass or delay/half-rate route select, both registered
// - data registers use only core clocks
// - half-rate stage runs on core full-rate clock at hrPhase edges
// - full-rate stage runs on core full-rate clock
// - bank holds four lanes of 12 pins
// - input captures SDR/DDR, delivers half/full rate
// - output takes half/full rate, drives SDR/DDR
// - enable takes half/full rate, drives SDR only
// - clock enable, async/sync reset, bypass per path
// - per-pin delay chain on input and output
// - open drain drives low only, else released
// - keeper starts at user mode, latches pad
// - keeper holds last level while net undriven
// - keeper and pull-up exclude each other
// - pull-up only in user mode on user pins
// - slew 0 slow, 1 fast, default 1
// - edge boost 0 off, 1 on, default on
// - swing code 0..3, default 2
package pad_cell_pkg;
   localparam int          LANES_PER_BANK = 4;    // lanes in one bank
   localparam int          PINS_PER_LANE  = 12;   // pins in one lane
   localparam int          ADDR_W         = 8;    // register address width
   localparam int          DLY_TAPS       = 8;    // delay chain length
   localparam logic [7:0]  OFS_CONFIG     = 8'h00; // configuration word
   localparam logic [7:0]  OFS_STATUS     = 8'h04; // status word
   localparam logic [0:0]  SLEW_SLOW      = 1'h0; // slow edge code
   localparam logic [0:0]  SLEW_FAST      = 1'h1; // fast edge code
   localparam logic [0:0]  BOOST_OFF      = 1'h0; // edge boost disabled
   localparam logic [0:0]  BOOST_ON       = 1'h1; // edge boost enabled
   localparam logic [1:0]  SWING_LOW      = 2'h0; // low swing
   localparam logic [1:0]  SWING_MED_LOW  = 2'h1; // medium low swing
   localparam logic [1:0]  SWING_MED_HIGH = 2'h2; // medium high swing
   localparam logic [1:0]  SWING_HIGH     = 2'h3; // high swing

   // configuration word, msb first
   typedef struct packed {
      logic [6:0] rsvd;       // reads zero
      logic [2:0] outDelay;   // output delay tap
      logic [2:0] inDelay;    // input delay tap
      logic       userPin;    // pin is a general user pin
      logic       diffMode;   // differential signalling
      logic       odtSeries;  // series on_die_termination in use
      logic [1:0] diffSwing;  // diff_swing_level code
      logic       edgeBoost;  // edge_boost_enable
      logic       slewFast;   // slew code
      logic       pullupEn;   // weak pull-up request
      logic       keeperEn;   // keeper request
      logic       openDrain;  // open-drain output
      logic       syncReset;  // path reset is synchronous
      logic       oeHalf;     // enable path half rate
      logic       outHalf;    // output path half rate
      logic       inHalf;     // input path half rate
      logic       outDdr;     // output double rate
      logic       inDdr;      // input double rate
      logic       oeBypass;   // enable path skips delay and half rate
      logic       outBypass;  // output path skips delay and half rate
      logic       inBypass;   // input path skips delay and half rate
   } cfg_t;

   // configuration after reset
   localparam cfg_t CFG_RESET = '{slewFast: SLEW_FAST, edgeBoost: BOOST_ON,
                                  diffSwing: SWING_MED_HIGH, default: '0};

   // static pad options toward the buffer
   typedef struct packed {
      logic       keepOn;     // keeper active
      logic       keepLevel;  // level the keeper holds
      logic       pullupOn;   // weak pull-up active
      logic       slewFast;   // effective slew
      logic       edgeBoost;  // effective edge boost
      logic [1:0] diffSwing;  // effective swing code
   } pad_opt_t;
endpackage : pad_cell_pkg

// ==== core/pad_cell.sv ====
// one programmable pad cell: input, output and enable paths plus pad options
`timescale 1ns/100ps
module pad_cell #(
   parameter logic [1:0] LANE_IDX = 2'h0,  // lane of this pin in its bank
   parameter logic [3:0] PIN_IDX  = 4'h0   // pin within its lane
) (
   input  wire logic                         clk_sys,      // full-rate core clock
   input  wire logic                         rst,          // global reset
   input  wire logic                         hrPhase,      // half-rate core clock edge marker
   input  wire logic                         clkEn,        // data path clock enable
   input  wire logic                         pathRst,      // data path reset from core
   input  wire logic                         configDone,   // device entered user mode
   input  wire logic [pad_cell_pkg::ADDR_W-1:0] regAddr,   // register address
   input  wire logic [31:0]                  regWrData,    // register write data
   input  wire logic                         regWr,        // write strobe
   input  wire logic                         regRd,        // read strobe
   output logic      [31:0]                  regRdData,    // read data, cycle after strobe
   input  wire logic [3:0]                   coreTxData,   // data to pad, pair 0 low
   input  wire logic [1:0]                   coreOeReq,    // enable to pad
   output logic      [3:0]                   coreRxData,   // data from pad, pair 0 low
   output logic                              coreRxValid,  // rx word strobe
   input  wire logic                         padIn,        // pad input level
   output logic                              padOutRise,   // level for clock-high half
   output logic                              padOutFall,   // level for clock-low half
   output logic                              padOe,        // buffer drives the pad
   output pad_cell_pkg::pad_opt_t            padOpt        // static pad options
);

   // control state on the global reset
   typedef struct packed {
      pad_cell_pkg::cfg_t     cfg;       // configuration word
      logic [31:0]            rdData;    // read answer
      logic                   userMode;  // user mode reached
      pad_cell_pkg::pad_opt_t opt;       // pad options
   } ctl_t;

   // data path state on the path reset
   typedef struct packed {
      logic                   inMeta;     // pad sync first stage
      logic                   inSync;     // pad sync second stage
      logic                   fallMeta;   // falling capture sync first stage
      logic                   fallSync;   // falling capture sync second stage
      logic [7:0]             riseDly;    // input delay chain, rise bit
      logic [7:0]             fallDly;    // input delay chain, fall bit
      logic [1:0]             inPair;     // first pair of a half-rate word
      logic [3:0]             rxData;     // word to core
      logic                   rxValid;    // word strobe to core
      logic [1:0]             txHi;       // second pair of a half-rate word
      logic                   oeHi;       // second enable of a half-rate word
      logic [7:0]             outRDly;    // output delay chain, rise bit
      logic [7:0]             outFDly;    // output delay chain, fall bit
      logic [7:0]             oeDly;      // enable delay chain
      logic                   outRise;    // rise level to buffer
      logic                   outFall;    // fall level to buffer
      logic                   outOe;      // enable to buffer
      logic                   keepLevel;  // level the keeper holds
   } dp_t;

   ctl_t ctl_ff;        // registered control
   ctl_t nxt_ctl;       // next control
   dp_t  dp_ff;         // registered data path
   dp_t  nxt_dp;        // next data path
   logic fallCap_ff;    // falling-edge pad capture
   logic dpAsyncClr;    // async path clear

   // pick one tap of a delay chain
   function automatic logic dlyTap(input logic [7:0] chain, input logic [2:0] sel);
      dlyTap = chain[sel];
   endfunction

   // async path clear when the async option is chosen
   assign dpAsyncClr = rst | (pathRst & ~ctl_ff.cfg.syncReset);

   // falling-edge capture of the pad, the second half of a DDR bit pair
   always_ff @(negedge clk_sys or posedge dpAsyncClr) begin
      if (dpAsyncClr) begin
         fallCap_ff <= 1'h0;
      end else begin
         fallCap_ff <= padIn;
      end
   end

   // control next state: register port, user mode and pad options
   always_comb begin
      pad_cell_pkg::cfg_t wcfg;  // decoded write value
      wcfg = pad_cell_pkg::cfg_t'(regWrData);
      nxt_ctl = ctl_ff;
      nxt_ctl.rdData = 32'h0000_0000;
      // configuration write
      if (regWr && regAddr == pad_cell_pkg::OFS_CONFIG) begin
         nxt_ctl.cfg = wcfg;
         nxt_ctl.cfg.rsvd = '0;
         // keeper wins when both are asked for
         if (wcfg.keeperEn) begin
            nxt_ctl.cfg.pullupEn = 1'h0;
         end else if (wcfg.pullupEn) begin
            nxt_ctl.cfg.keeperEn = 1'h0;
         end
      end
      // read answer, unmapped reads zero
      if (regRd) begin
         unique case (regAddr)
            pad_cell_pkg::OFS_CONFIG: begin
               nxt_ctl.rdData = 32'(ctl_ff.cfg);
            end
            pad_cell_pkg::OFS_STATUS: begin
               nxt_ctl.rdData = {20'h0_0000, LANE_IDX, PIN_IDX,
                                 ctl_ff.opt.pullupOn, ctl_ff.opt.keepOn,
                                 dp_ff.keepLevel, dp_ff.inSync,
                                 dp_ff.outOe, ctl_ff.userMode};
            end
            default: begin
               nxt_ctl.rdData = 32'h0000_0000;
            end
         endcase
      end
      // user mode is entered once and kept
      if (configDone) begin
         nxt_ctl.userMode = 1'h1;
      end
      // keeper only in user mode
      nxt_ctl.opt.keepOn = ctl_ff.cfg.keeperEn & nxt_ctl.userMode;
      nxt_ctl.opt.keepLevel = dp_ff.keepLevel;
      // pull-up only in user mode, on user pins, never with keeper
      nxt_ctl.opt.pullupOn = ctl_ff.cfg.pullupEn & ~ctl_ff.cfg.keeperEn
                             & ctl_ff.cfg.userPin & nxt_ctl.userMode;
      // slew setting has no effect under series termination
      nxt_ctl.opt.slewFast = ctl_ff.cfg.odtSeries ? pad_cell_pkg::SLEW_SLOW
                                                  : ctl_ff.cfg.slewFast;
      nxt_ctl.opt.edgeBoost = ctl_ff.cfg.edgeBoost;
      nxt_ctl.opt.diffSwing = ctl_ff.cfg.diffSwing;
   end

   // control registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctl_ff.cfg      <= pad_cell_pkg::CFG_RESET;
         ctl_ff.rdData   <= 32'h0000_0000;
         ctl_ff.userMode <= 1'h0;
         ctl_ff.opt      <= '{slewFast: pad_cell_pkg::SLEW_FAST, edgeBoost: pad_cell_pkg::BOOST_ON,
                              diffSwing: pad_cell_pkg::SWING_MED_HIGH, default: '0};
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // data path next state
   always_comb begin
      logic [1:0] pair;    // captured pair, rise bit low
      logic       rBit;    // rise bit out of the delay chain
      logic       fBit;    // fall bit out of the delay chain
      logic [1:0] txPair;  // pair launched this cycle
      logic       oeBit;   // enable launched this cycle
      logic       odOe;    // enable after open-drain gating
      pair   = 2'h0;
      rBit   = 1'h0;
      fBit   = 1'h0;
      txPair = 2'h0;
      oeBit  = 1'h0;
      odOe   = 1'h0;
      nxt_dp = dp_ff;
      // pad synchronisers run free
      nxt_dp.inMeta   = padIn;
      nxt_dp.inSync   = dp_ff.inMeta;
      nxt_dp.fallMeta = fallCap_ff;
      nxt_dp.fallSync = dp_ff.fallMeta;
      nxt_dp.rxValid  = 1'h0;
      // synchronous path clear when chosen
      if (pathRst && ctl_ff.cfg.syncReset) begin
         nxt_dp = '0;
         nxt_dp.inMeta   = padIn;
         nxt_dp.inSync   = dp_ff.inMeta;
         nxt_dp.fallMeta = fallCap_ff;
         nxt_dp.fallSync = dp_ff.fallMeta;
         nxt_dp.keepLevel = dp_ff.keepLevel;
      end else if (clkEn) begin
         // input delay chains
         nxt_dp.riseDly = {dp_ff.riseDly[6:0], dp_ff.inSync};
         nxt_dp.fallDly = {dp_ff.fallDly[6:0], dp_ff.fallSync};
         if (ctl_ff.cfg.inBypass) begin
            rBit = dp_ff.inSync;
            fBit = dp_ff.fallSync;
         end else begin
            rBit = dlyTap(dp_ff.riseDly, ctl_ff.cfg.inDelay);
            fBit = dlyTap(dp_ff.fallDly, ctl_ff.cfg.inDelay);
         end
         // rise bit first, fall bit second in DDR
         pair = ctl_ff.cfg.inDdr ? {fBit, rBit} : {1'h0, rBit};
         // hand to core at half or full rate
         if (ctl_ff.cfg.inHalf && !ctl_ff.cfg.inBypass) begin
            if (hrPhase) begin
               nxt_dp.rxData  = {pair, dp_ff.inPair};
               nxt_dp.rxValid = 1'h1;
            end else begin
               nxt_dp.inPair = pair;
            end
         end else begin
            nxt_dp.rxData  = {2'h0, pair};
            nxt_dp.rxValid = 1'h1;
         end
         // output pair and enable from core at half or full rate
         if (ctl_ff.cfg.outHalf && !ctl_ff.cfg.outBypass) begin
            if (hrPhase) begin
               txPair = coreTxData[1:0];
               nxt_dp.txHi = coreTxData[3:2];
            end else begin
               txPair = dp_ff.txHi;
            end
         end else begin
            txPair = coreTxData[1:0];
         end
         if (ctl_ff.cfg.oeHalf && !ctl_ff.cfg.oeBypass) begin
            if (hrPhase) begin
               oeBit = coreOeReq[0];
               nxt_dp.oeHi = coreOeReq[1];
            end else begin
               oeBit = dp_ff.oeHi;
            end
         end else begin
            oeBit = coreOeReq[0];
         end
         // single rate repeats the rise bit in both halves
         if (!ctl_ff.cfg.outDdr) begin
            txPair[1] = txPair[0];
         end
         // output delay chains
         nxt_dp.outRDly = {dp_ff.outRDly[6:0], txPair[0]};
         nxt_dp.outFDly = {dp_ff.outFDly[6:0], txPair[1]};
         nxt_dp.oeDly   = {dp_ff.oeDly[6:0], oeBit};
         if (ctl_ff.cfg.outBypass) begin
            nxt_dp.outRise = coreTxData[0];
            nxt_dp.outFall = ctl_ff.cfg.outDdr ? coreTxData[1] : coreTxData[0];
         end else begin
            nxt_dp.outRise = ctl_ff.cfg.outDelay == 3'h0 ? txPair[0]
                             : dlyTap(dp_ff.outRDly, 3'(ctl_ff.cfg.outDelay - 3'h1));
            nxt_dp.outFall = ctl_ff.cfg.outDelay == 3'h0 ? txPair[1]
                             : dlyTap(dp_ff.outFDly, 3'(ctl_ff.cfg.outDelay - 3'h1));
         end
         if (ctl_ff.cfg.oeBypass) begin
            nxt_dp.outOe = coreOeReq[0];
         end else begin
            nxt_dp.outOe = ctl_ff.cfg.outDelay == 3'h0 ? oeBit
                           : dlyTap(dp_ff.oeDly, 3'(ctl_ff.cfg.outDelay - 3'h1));
         end
         // open drain: release instead of driving high
         if (ctl_ff.cfg.openDrain) begin
            odOe = nxt_dp.outOe & ~nxt_dp.outRise;
            nxt_dp.outOe   = odOe;
            nxt_dp.outRise = 1'h0;
            nxt_dp.outFall = 1'h0;
         end
      end
      // keeper: latch at user-mode entry, then follow the last level
      if (ctl_ff.cfg.keeperEn) begin
         if (!ctl_ff.userMode) begin
            nxt_dp.keepLevel = dp_ff.inSync;
         end else if (dp_ff.outOe) begin
            nxt_dp.keepLevel = dp_ff.outRise;
         end else begin
            nxt_dp.keepLevel = dp_ff.inSync;
         end
      end
   end

   // data path registers, all on the full-rate core clock
   always_ff @(posedge clk_sys or posedge dpAsyncClr) begin
      if (dpAsyncClr) begin
         dp_ff <= '0;
      end else begin
         dp_ff <= nxt_dp;
      end
   end

   // outputs straight from registers
   assign regRdData   = ctl_ff.rdData;
   assign coreRxData  = dp_ff.rxData;
   assign coreRxValid = dp_ff.rxValid;
   assign padOutRise  = dp_ff.outRise;
   assign padOutFall  = dp_ff.outFall;
   assign padOe       = dp_ff.outOe;
   assign padOpt      = ctl_ff.opt;

endmodule : pad_cell  // pad_cell

// ==== dv/pad_cell_chk.sv ====
// concurrent checks on the pad cell ports
`timescale 1ns/100ps
module pad_cell_chk (
   input wire logic                              clk_sys,     // core clock
   input wire logic                              rst,         // global reset
   input wire logic                              clkEn,       // data path enable
   input wire logic                              pathRst,     // data path reset
   input wire logic                              configDone,  // user mode reached
   input wire logic [pad_cell_pkg::ADDR_W-1:0]   regAddr,     // register address
   input wire logic [31:0]                       regWrData,   // write data
   input wire logic                              regWr,       // write strobe
   input wire logic                              regRd,       // read strobe
   input wire logic [31:0]                       regRdData,   // read data
   input wire logic [3:0]                        coreTxData,  // data to pad
   input wire logic [1:0]                        coreOeReq,   // enable to pad
   input wire logic [3:0]                        coreRxData,  // data from pad
   input wire logic                              coreRxValid, // rx strobe
   input wire logic                              padOutRise,  // clock-high level
   input wire logic                              padOutFall,  // clock-low level
   input wire logic                              padOe,       // buffer drive
   input wire pad_cell_pkg::pad_opt_t            padOpt       // pad options
);
   pad_cell_pkg::cfg_t cfg_ff;   // shadow of the configuration word
   pad_cell_pkg::cfg_t nxt_cfg;  // word a write would store
   logic [3:0]         age_ff;   // cycles since last config write, saturating
   logic               done_ff;  // user mode seen
   // stored form of a config write: reserved cleared, keeper beats pull-up
   always_comb begin
      nxt_cfg = pad_cell_pkg::cfg_t'(regWrData);
      nxt_cfg.rsvd = 7'h00;
      if (nxt_cfg.keeperEn) begin
         nxt_cfg.pullupEn = 1'b0;
      end
   end
   // shadow update; age lets pipelines flush after a change
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_ff <= pad_cell_pkg::CFG_RESET;
         age_ff <= 4'hF;
         done_ff <= 1'b0;
      end else begin
         if (regWr && regAddr == pad_cell_pkg::OFS_CONFIG) begin
            cfg_ff <= nxt_cfg;
            age_ff <= 4'h0;
         end else if (age_ff != 4'hF) begin
            age_ff <= age_ff + 4'h1;
         end
         done_ff <= done_ff | configDone;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // settled full-rate launch with no delay in the way
   sequence s_launch;
      age_ff >= 4'hA && !cfg_ff.outHalf && !cfg_ff.oeHalf && !pathRst && !regWr && clkEn
         && (cfg_ff.outBypass || cfg_ff.outDelay == 3'h0) && cfg_ff.outBypass == cfg_ff.oeBypass;
   endsequence
   chk_read_idle: assert property (!regRd |=> regRdData == 32'h0)
      else $error("read data not zero outside read answer");
   chk_keep_pull_excl: assert property (!(padOpt.keepOn && padOpt.pullupOn))
      else $error("keeper and pull-up both active");
   chk_pullup_user: assert property (age_ff >= 4'h3 && padOpt.pullupOn |->
      done_ff && cfg_ff.pullupEn && cfg_ff.userPin)
      else $error("pull-up active outside user pin in user mode");
   chk_slew_boost: assert property (age_ff >= 4'h3 |-> padOpt.edgeBoost == cfg_ff.edgeBoost
      && padOpt.slewFast == (cfg_ff.slewFast & ~cfg_ff.odtSeries))
      else $error("slew or edge boost differs from setting");
   chk_swing_code: assert property (age_ff >= 4'h3 |-> padOpt.diffSwing == cfg_ff.diffSwing)
      else $error("swing code differs from setting");
   chk_pad_launch: assert property (s_launch ##0 !cfg_ff.openDrain |=> pathRst || (padOutRise == $past(coreTxData[0])
      && padOutFall == $past(cfg_ff.outDdr ? coreTxData[1] : coreTxData[0])
      && padOe == $past(coreOeReq[0])))
      else $error("pad launch wrong");
   chk_open_drain: assert property (s_launch ##0 cfg_ff.openDrain |=> pathRst || (!padOutRise && !padOutFall
      && padOe == ($past(coreOeReq[0]) & ~$past(coreTxData[0]))))
      else $error("open drain drives high");
   chk_hold_clken: assert property (!clkEn && !pathRst && !regWr |=> pathRst || $stable(coreRxData))
      else $error("rx data moved with clock enable low");
   chk_path_reset: assert property (pathRst |=> coreRxData == 4'h0 && !coreRxValid)
      else $error("path reset did not clear rx");
   chk_rx_sdr: assert property (coreRxValid && age_ff >= 4'hC && !cfg_ff.inDdr
      && (!cfg_ff.inHalf || cfg_ff.inBypass) |-> coreRxData[3:1] == 3'h0)
      else $error("single rate rx has upper bits set");
endmodule // pad_cell_chk
bind pad_cell pad_cell_chk pad_cell_chk_i (.clk_sys, .rst, .clkEn, .pathRst, .configDone, .regAddr,
   .regWrData, .regWr, .regRd, .regRdData, .coreTxData, .coreOeReq, .coreRxData, .coreRxValid,
   .padOutRise, .padOutFall, .padOe, .padOpt);

// ==== dv/pad_cell_tb_top.sv ====
// self-checking bench for the pad cell
`timescale 1ns/100ps
module pad_cell_tb_top;
   logic clk_sys, rst, hrPhase, clkEn, pathRst, configDone, regWr, regRd;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, v;
   logic [3:0] coreTxData, coreRxData;
   logic [1:0] coreOeReq;
   logic coreRxValid, padIn, padOutRise, padOutFall, padOe, extDrive, extLevel;
   pad_cell_pkg::pad_opt_t padOpt;
   pad_cell_pkg::cfg_t c;
   int seed, bad_count, total_checks;
   pad_cell #(.LANE_IDX(2'h2), .PIN_IDX(4'hB)) pad_cell_i (.clk_sys, .rst, .hrPhase, .clkEn, .pathRst,
      .configDone, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .coreTxData, .coreOeReq,
      .coreRxData, .coreRxValid, .padIn, .padOutRise, .padOutFall, .padOe, .padOpt);
   pad_net_model pad_net_model_i (.clk_sys, .padOutRise, .padOutFall, .padOe, .padOpt, .extDrive,
      .extLevel, .padLevel(padIn));
   // clock, 25 ns period
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // half-rate edge marker every other cycle
   always @(posedge clk_sys) hrPhase <= rst ? 1'b0 : ~hrPhase;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // expected {rise, fall, oe} for one launched word
   function automatic logic [2:0] tx_exp(input logic [3:0] t, input logic [1:0] o, input logic ddr, od);
      return od ? {2'b00, o[0] & ~t[0]} : {t[0], ddr ? t[1] : t[0], o[0]};
   endfunction
   // random output traffic through one path setting
   task automatic tx_run(input logic ddr, od, byp, input logic [2:0] dly);
      logic [3:0] h [0:31];
      logic [1:0] o [0:31];
      int k;
      c = pad_cell_pkg::CFG_RESET;
      {c.outDdr, c.openDrain, c.outBypass, c.oeBypass, c.outDelay} = {ddr, od, byp, byp, dly};
      wr(pad_cell_pkg::OFS_CONFIG, c);
      for (int i = 0; i < 32; i++) begin
         @(posedge clk_sys);
         h[i] = 4'($random(seed));
         o[i] = 2'($random(seed));
         coreTxData <= h[i];
         coreOeReq <= o[i];
         #1 k = i - 1 - (byp ? 0 : int'(dly));
         if (i > 12) check(32'({padOutRise, padOutFall, padOe}), 32'(tx_exp(h[k], o[k], ddr, od)));
      end
      $display("tx ddr=%0d od=%0d byp=%0d dly=%0d done", ddr, od, byp, dly);
   endtask
   // steady pad level captured, then held under clock enable low, then cleared
   task automatic rx_run(input logic ddr, half, byp, lvl);
      logic [1:0] p;
      logic [3:0] e;
      c = pad_cell_pkg::CFG_RESET;
      {c.inDdr, c.inHalf, c.inBypass, c.inDelay, c.syncReset} = {ddr, half, byp, 3'($random(seed)), 1'($random(seed))};
      wr(pad_cell_pkg::OFS_CONFIG, c);
      coreOeReq <= 2'h0;
      extDrive <= 1'b1;
      extLevel <= lvl;
      wait_n(20);
      for (int i = 0; i < 4 && coreRxValid !== 1'b1; i++) wait_n(1);
      p = ddr ? {lvl, lvl} : {1'b0, lvl};
      e = (half && !byp) ? {p, p} : {2'b00, p};
      check(32'({coreRxValid, coreRxData}), 32'({1'b1, e}));
      clkEn <= 1'b0;
      extLevel <= ~lvl;
      wait_n(8);
      check(32'(coreRxData), 32'(e));
      clkEn <= 1'b1;
      pathRst <= 1'b1;
      wait_n(1);
      pathRst <= 1'b0;
      check(32'(coreRxData), 32'h0);
      $display("rx ddr=%0d half=%0d byp=%0d done", ddr, half, byp);
   endtask
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial begin
      #(25 * 20000);
      bad_count++;
      conclude();
   end
   // main sequence
   initial begin
      {rst, clkEn, pathRst, configDone, regWr, regRd, extDrive, extLevel} = 8'hC3;
      {regAddr, regWrData, coreTxData, coreOeReq} = '0;
      seed = 52;
      bad_count = 0;
      total_checks = 0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rd(pad_cell_pkg::OFS_CONFIG, v);
      check(v, 32'h0000B000);
      wr(pad_cell_pkg::OFS_CONFIG, 32'hFE000000);
      rd(pad_cell_pkg::OFS_CONFIG, v);
      check(v, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, v);
      check(v, 32'h0);
      $display("register map done");
      tx_run(1'b0, 1'b0, 1'b0, 3'h0);
      tx_run(1'b1, 1'b0, 1'b0, 3'h0);
      tx_run(1'b1, 1'b0, 1'b0, 3'h7);
      tx_run(1'b1, 1'b0, 1'b1, 3'h5);
      tx_run(1'b1, 1'b1, 1'b0, 3'h0);
      for (int m = 0; m < 8; m++) rx_run(m[0], m[1], m[2], 1'($random(seed)));
      extDrive <= 1'b0;
      c = pad_cell_pkg::CFG_RESET;
      {c.pullupEn, c.userPin} = 2'b11;
      wr(pad_cell_pkg::OFS_CONFIG, c);
      wait_n(6);
      check(32'(padOpt.pullupOn), 32'h0);
      configDone <= 1'b1;
      wait_n(8);
      rd(pad_cell_pkg::OFS_STATUS, v);
      check(v & 32'h25, 32'h25);
      c.userPin = 1'b0;
      wr(pad_cell_pkg::OFS_CONFIG, c);
      wait_n(6);
      check(32'(padOpt.pullupOn), 32'h0);
      c.keeperEn = 1'b1;
      wr(pad_cell_pkg::OFS_CONFIG, c);
      rd(pad_cell_pkg::OFS_CONFIG, v);
      check(v[11:10], 32'h1);
      coreTxData <= 4'hF;
      coreOeReq <= 2'h1;
      wait_n(12);
      coreOeReq <= 2'h0;
      wait_n(12);
      rd(pad_cell_pkg::OFS_STATUS, v);
      check(v[11:0], {2'h2, 4'hB, 6'b011101});
      extDrive <= 1'b1;
      extLevel <= 1'b0;
      wait_n(8);
      extDrive <= 1'b0;
      wait_n(8);
      rd(pad_cell_pkg::OFS_STATUS, v);
      check(v[5:2], 32'h4);
      $display("keeper and pull-up done");
      for (int s = 0; s < 4; s++) begin
         c = pad_cell_pkg::CFG_RESET;
         {c.diffMode, c.keeperEn, c.diffSwing, c.edgeBoost, c.odtSeries} = {2'b10, 2'(s), s[0], s[1]};
         wr(pad_cell_pkg::OFS_CONFIG, c);
         wait_n(4);
         check(32'({padOpt.slewFast, padOpt.edgeBoost, padOpt.diffSwing}), 32'({~s[1], s[0], 2'(s)}));
      end
      $display("pad options done");
      conclude();
   end
endmodule // pad_cell_tb_top

// ==== dv/pad_net_model.sv ====
// pad net model: buffer drive, external driver, pull-up and keeper
`timescale 1ns/100ps
module pad_net_model (
   input  wire logic                   clk_sys,    // picks the ddr half
   input  wire logic                   padOutRise, // clock-high level
   input  wire logic                   padOutFall, // clock-low level
   input  wire logic                   padOe,      // buffer drives
   input  wire pad_cell_pkg::pad_opt_t padOpt,     // weak options
   input  wire logic                   extDrive,   // external driver on
   input  wire logic                   extLevel,   // external driver level
   output logic                        padLevel    // resolved net level
);
   logic float_ff = 1'b0; // bare net wanders every cycle
   // an undriven, unheld net never shows a steady value
   always_ff @(posedge clk_sys) begin
      float_ff <= ~padLevel;
   end
   // strongest source wins
   always_comb begin
      if (padOe) begin
         padLevel = clk_sys ? padOutRise : padOutFall;
      end else if (extDrive) begin
         padLevel = extLevel;
      end else if (padOpt.pullupOn) begin
         padLevel = 1'b1;
      end else if (padOpt.keepOn) begin
         padLevel = padOpt.keepLevel;
      end else begin
         padLevel = float_ff;
      end
   end
endmodule // pad_net_model
